//--- ipais_pkg.sv
// Constants shared by the port address decoder, its register slave and the
// interrupt router: bus widths, register offsets, field positions, reset values.
// Assumes a 10-bit host I/O address and four ports of eight registers each.
package ipais_pkg;

  // ************************************************************************
  // Host bus and card geometry.
  // ************************************************************************
  localparam int ADDR_W = 10;
  localparam int SW_W = 7;
  localparam int NPORT = 4;
  localparam int REG_SEL_W = 3;
  localparam int IRQ_W = 16;
  localparam int SEL_W = 4;

  // ************************************************************************
  // Legal base address window for the configuring party.
  // ************************************************************************
  localparam logic [ADDR_W-1:0] AT_MIN = 10'h100;
  localparam logic [ADDR_W-1:0] XT_MIN = 10'h200;
  localparam logic [ADDR_W-1:0] DISK_LO = 10'h1f0;
  localparam logic [ADDR_W-1:0] DISK_HI = 10'h1f8;
  localparam logic [ADDR_W-1:0] CARD_LAST = 10'h01f;

  // ************************************************************************
  // Interrupt level codes held in the routing register.
  // ************************************************************************
  localparam logic [SEL_W-1:0] IRQ_LOW_MIN = 4'h2;
  localparam logic [SEL_W-1:0] IRQ_LOW_MAX = 4'h7;
  localparam logic [SEL_W-1:0] IRQ_HIGH_MIN = 4'ha;
  localparam logic [SEL_W-1:0] IRQ_HIGH_MAX = 4'hf;
  localparam logic [SEL_W-1:0] IRQ_RESERVED = 4'hd;

  // ************************************************************************
  // Register slave layout.
  // ************************************************************************
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFF_ROUTE = 8'h00;
  localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFF_MASK = 8'h08;
  localparam logic [AXI_AW-1:0] OFF_INFO = 8'h0c;
  localparam int EV_W = 5;
  localparam int EV_BASE_BAD = 4;
  localparam int INFO_WIDE = 7;
  localparam int INFO_REQ = 8;
  localparam int INFO_LEGAL = 12;
  localparam logic [NPORT*SEL_W-1:0] ROUTE_RST = 16'h0000;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************************
  // Pin synchroniser layout: address, enable, strobes, switches, slot, requests.
  // ************************************************************************
  localparam int SYNC_W = 25;
  localparam int SY_AEN = 10;
  localparam int SY_IOR = 11;
  localparam int SY_IOW = 12;
  localparam int SY_SW = 13;
  localparam int SY_WIDE = 20;
  localparam int SY_REQ = 21;
  localparam logic [SYNC_W-1:0] SYNC_RST = 25'h0001c00;
  localparam logic [1:0] SETTLE_DONE = 2'h3;

endpackage

//--- ipais_route_if.sv
// Bundle between the decoder top and one interrupt router instance.
// Assumes the router is purely combinational and the top registers its result.
`timescale 1ns/1ps
interface ipais_route_if;
  import ipais_pkg::*;
  logic [SEL_W-1:0] sel;
  logic wide;
  logic req;
  logic [IRQ_W-1:0] lineLvl;
  logic [IRQ_W-1:0] lineDrv;
  modport src (output sel, output wide, output req, input lineLvl, input lineDrv);
  modport rtr (input sel, input wide, input req, output lineLvl, output lineDrv);
endinterface

//--- ipais_irq_route.sv
// Steers one port's interrupt request onto the bus line its selection names.
// Assumes inputs are already synchronised; outputs are registered by the top.
`timescale 1ns/1ps
module ipais_irq_route (
  ipais_route_if.rtr rt
);
  import ipais_pkg::*;

  logic lowOk;
  logic highOk;

  // ************************************************************************
  // Level selection.
  // ************************************************************************
  // An illegal code routes nowhere, so a stray setting can never fight a line.
  always_comb begin
    lowOk = (rt.sel >= IRQ_LOW_MIN) && (rt.sel <= IRQ_LOW_MAX);
    highOk = rt.wide && (rt.sel >= IRQ_HIGH_MIN) && (rt.sel <= IRQ_HIGH_MAX)
             && (rt.sel != IRQ_RESERVED);
    rt.lineLvl = '0;
    rt.lineDrv = '0;
    if (lowOk || highOk) begin
      rt.lineDrv[rt.sel] = 1'b1;
      rt.lineLvl[rt.sel] = rt.req;
    end
  end

endmodule

//--- isa_port_address_irq_select.sv
// Four-port card selection: base address compare, register select, IRQ routing,
// with an AXI4-Lite register slave for routing, events and status.
// Assumes host bus pins are asynchronous to clk and are settled for several cycles.
`timescale 1ns/1ps

// Overview of operation
// - Match A9..A3 against switch-set base
// - Low three address bits pick register
// - Each port drives one chosen level
// - Narrow slot disables levels ten to fifteen
// - Ports may share one request line
module isa_port_address_irq_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ipais_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ipais_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [ipais_pkg::ADDR_W-1:0] isaAddr,
  input wire logic isaAen,
  input wire logic isaIorN,
  input wire logic isaIowN,
  input wire logic [ipais_pkg::SW_W-1:0] baseSwitch,
  input wire logic slotWide,
  input wire logic [ipais_pkg::NPORT-1:0] portReq,
  output logic [ipais_pkg::NPORT-1:0] portSel,
  output logic [ipais_pkg::REG_SEL_W-1:0] regSel,
  output logic dataOe,
  output logic [ipais_pkg::IRQ_W-1:0] isaIrqLvl,
  output logic [ipais_pkg::IRQ_W-1:0] isaIrqOe,
  output logic irq
);
  import ipais_pkg::*;

  // ************************************************************************
  // Declarations.
  // ************************************************************************
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic [ADDR_W-1:0] sAddr;
  logic [SW_W-1:0] sSw;
  logic [NPORT-1:0] sReq;
  logic sAen;
  logic sIor;
  logic sIow;
  logic sWide;
  logic [NPORT-1:0] portSel_ff, nxt_portSel;
  logic [REG_SEL_W-1:0] regSel_ff, nxt_regSel;
  logic dataOe_ff, nxt_dataOe;
  logic [IRQ_W-1:0] irqLvl_ff, nxt_irqLvl;
  logic [IRQ_W-1:0] irqOe_ff, nxt_irqOe;
  logic [IRQ_W-1:0] lvlArr [NPORT];
  logic [IRQ_W-1:0] drvArr [NPORT];
  logic [ADDR_W-1:0] baseAddr;
  logic baseBad;
  logic [1:0] settle_ff, nxt_settle;
  logic badPrev_ff, nxt_badPrev;
  logic [NPORT-1:0] reqPrev_ff, nxt_reqPrev;
  logic [EV_W-1:0] evSet;
  logic [NPORT*SEL_W-1:0] route_ff, nxt_route;
  logic [EV_W-1:0] status_ff, nxt_status;
  logic [EV_W-1:0] mask_ff, nxt_mask;
  logic irq_ff, nxt_irq;
  logic awReady_ff, nxt_awReady;
  logic wReady_ff, nxt_wReady;
  logic awHave_ff, nxt_awHave;
  logic wHave_ff, nxt_wHave;
  logic [AXI_AW-1:0] awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  logic arReady_ff, nxt_arReady;
  logic rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0] rResp_ff, nxt_rResp;
  logic doWrite;
  logic [AXI_AW-1:0] wrWord;
  logic [AXI_AW-1:0] rdWord;

  // ************************************************************************
  // Pin synchronisers.
  // ************************************************************************
  // Strobes and the address enable reset to their idle level so that no
  // select or data drive can flicker out while the chain fills after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= {portReq, slotWide, baseSwitch, isaIowN, isaIorN, isaAen, isaAddr};
      sync_ff <= meta_ff;
    end
  end

  assign sAddr = sync_ff[ADDR_W-1:0];
  assign sAen = sync_ff[SY_AEN];
  assign sIor = !sync_ff[SY_IOR];
  assign sIow = !sync_ff[SY_IOW];
  assign sSw = sync_ff[SY_SW +: SW_W];
  assign sWide = sync_ff[SY_WIDE];
  assign sReq = sync_ff[SY_REQ +: NPORT];

  // ************************************************************************
  // Address decode.
  // ************************************************************************
  // Port k answers at base plus 8k; a block that would wrap past the top of
  // the I/O space is simply not decoded rather than aliasing near zero.
  always_comb begin
    logic [SW_W:0] blk;
    blk = '0;
    nxt_portSel = '0;
    for (int k = 0; k < NPORT; k++) begin
      blk = {1'b0, sSw} + (SW_W+1)'(k);
      if (!sAen && !blk[SW_W] && (sAddr[ADDR_W-1:REG_SEL_W] == blk[SW_W-1:0])) begin
        nxt_portSel[k] = 1'b1;
      end
    end
    nxt_regSel = sAddr[REG_SEL_W-1:0];
    nxt_dataOe = (|nxt_portSel) && sIor && !sIow;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      portSel_ff <= '0;
      regSel_ff <= '0;
      dataOe_ff <= 1'b0;
    end else begin
      portSel_ff <= nxt_portSel;
      regSel_ff <= nxt_regSel;
      dataOe_ff <= nxt_dataOe;
    end
  end

  // ************************************************************************
  // Interrupt routing, one router per port.
  // ************************************************************************
  ipais_route_if rt [NPORT] ();

  for (genvar k = 0; k < NPORT; k++) begin : gPort
    assign rt[k].sel = route_ff[k*SEL_W +: SEL_W];
    assign rt[k].wide = sWide;
    assign rt[k].req = sReq[k];
    assign lvlArr[k] = rt[k].lineLvl;
    assign drvArr[k] = rt[k].lineDrv;
    ipais_irq_route uRoute (
      .rt(rt[k].rtr)
    );
  end

  // Ports on the same level are merged: the line is driven while any of them
  // claims it and is high while any of them requests.
  always_comb begin
    nxt_irqLvl = '0;
    nxt_irqOe = '0;
    for (int k = 0; k < NPORT; k++) begin
      nxt_irqLvl = nxt_irqLvl | lvlArr[k];
      nxt_irqOe = nxt_irqOe | drvArr[k];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqLvl_ff <= '0;
      irqOe_ff <= '0;
    end else begin
      irqLvl_ff <= nxt_irqLvl;
      irqOe_ff <= nxt_irqOe;
    end
  end

  // ************************************************************************
  // Event detection.
  // ************************************************************************
  // The base check waits for the synchronisers to fill, otherwise the reset
  // image of the switches would raise a false alarm on every power-up.
  always_comb begin
    baseAddr = {sSw, {REG_SEL_W{1'b0}}};
    baseBad = (baseAddr < (sWide ? AT_MIN : XT_MIN))
              || ((baseAddr <= DISK_HI) && ((baseAddr + CARD_LAST) >= DISK_LO))
              || (baseAddr > ~CARD_LAST);
    nxt_settle = (settle_ff == SETTLE_DONE) ? settle_ff : settle_ff + 2'h1;
    nxt_badPrev = (settle_ff == SETTLE_DONE) ? baseBad : 1'b0;
    nxt_reqPrev = sReq;
    evSet = '0;
    evSet[NPORT-1:0] = sReq & ~reqPrev_ff;
    evSet[EV_BASE_BAD] = (settle_ff == SETTLE_DONE) && baseBad && !badPrev_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_ff <= '0;
      badPrev_ff <= 1'b0;
      reqPrev_ff <= '0;
    end else begin
      settle_ff <= nxt_settle;
      badPrev_ff <= nxt_badPrev;
      reqPrev_ff <= nxt_reqPrev;
    end
  end

  // ************************************************************************
  // AXI4-Lite write channel.
  // ************************************************************************
  // Address and data are caught independently; the write happens in the cycle
  // both are present, so either order works and one write is in flight at most.
  always_comb begin
    nxt_awHave = awHave_ff;
    nxt_wHave = wHave_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wData = wData_ff;
    nxt_wStrb = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp = bResp_ff;
    if (awvalid && awReady_ff) begin
      nxt_awHave = 1'b1;
      nxt_awAddr = awaddr;
    end
    if (wvalid && wReady_ff) begin
      nxt_wHave = 1'b1;
      nxt_wData = wdata;
      nxt_wStrb = wstrb;
    end
    wrWord = {nxt_awAddr[AXI_AW-1:2], 2'h0};
    doWrite = nxt_awHave && nxt_wHave && !bValid_ff;
    if (bValid_ff && bready) begin
      nxt_bValid = 1'b0;
    end
    if (doWrite) begin
      nxt_awHave = 1'b0;
      nxt_wHave = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = (wrWord == OFF_ROUTE || wrWord == OFF_STATUS || wrWord == OFF_MASK)
                  ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_awReady = !nxt_awHave && !nxt_bValid;
    nxt_wReady = !nxt_wHave && !nxt_bValid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
      awReady_ff <= 1'b1;
      wReady_ff <= 1'b1;
    end else begin
      awHave_ff <= nxt_awHave;
      wHave_ff <= nxt_wHave;
      awAddr_ff <= nxt_awAddr;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      awReady_ff <= nxt_awReady;
      wReady_ff <= nxt_wReady;
    end
  end

  // ************************************************************************
  // Register file and interrupt output.
  // ************************************************************************
  // A new event in the same cycle as its write-one clear stays set.
  always_comb begin
    nxt_route = route_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    if (doWrite && wrWord == OFF_ROUTE) begin
      if (nxt_wStrb[0]) begin
        nxt_route[7:0] = nxt_wData[7:0];
      end
      if (nxt_wStrb[1]) begin
        nxt_route[15:8] = nxt_wData[15:8];
      end
    end
    if (doWrite && wrWord == OFF_MASK && nxt_wStrb[0]) begin
      nxt_mask = nxt_wData[EV_W-1:0];
    end
    if (doWrite && wrWord == OFF_STATUS && nxt_wStrb[0]) begin
      nxt_status = status_ff & ~nxt_wData[EV_W-1:0];
    end
    nxt_status = nxt_status | evSet;
    nxt_irq = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      route_ff <= ROUTE_RST;
      mask_ff <= MASK_RST;
      status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      route_ff <= nxt_route;
      mask_ff <= nxt_mask;
      status_ff <= nxt_status;
      irq_ff <= nxt_irq;
    end
  end

  // ************************************************************************
  // AXI4-Lite read channel.
  // ************************************************************************
  // Data are captured at the address handshake, so a read shows the state of
  // that cycle even if the master is slow to accept it.
  always_comb begin
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    rdWord = {araddr[AXI_AW-1:2], 2'h0};
    if (rValid_ff && rready) begin
      nxt_rValid = 1'b0;
    end
    if (arvalid && arReady_ff) begin
      nxt_rValid = 1'b1;
      nxt_rData = '0;
      nxt_rResp = RESP_OKAY;
      unique case (rdWord)
        OFF_ROUTE: nxt_rData[NPORT*SEL_W-1:0] = route_ff;
        OFF_STATUS: nxt_rData[EV_W-1:0] = status_ff;
        OFF_MASK: nxt_rData[EV_W-1:0] = mask_ff;
        OFF_INFO: begin
          nxt_rData[SW_W-1:0] = sSw;
          nxt_rData[INFO_WIDE] = sWide;
          nxt_rData[INFO_REQ +: NPORT] = sReq;
          nxt_rData[INFO_LEGAL] = !baseBad;
        end
        default: nxt_rResp = RESP_SLVERR;
      endcase
    end
    nxt_arReady = !nxt_rValid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= RESP_OKAY;
      arReady_ff <= 1'b1;
    end else begin
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
      arReady_ff <= nxt_arReady;
    end
  end

  // ************************************************************************
  // Outputs, each straight from a flip-flop.
  // ************************************************************************
  assign awready = awReady_ff;
  assign wready = wReady_ff;
  assign bvalid = bValid_ff;
  assign bresp = bResp_ff;
  assign arready = arReady_ff;
  assign rvalid = rValid_ff;
  assign rdata = rData_ff;
  assign rresp = rResp_ff;
  assign portSel = portSel_ff;
  assign regSel = regSel_ff;
  assign dataOe = dataOe_ff;
  assign isaIrqLvl = irqLvl_ff;
  assign isaIrqOe = irqOe_ff;
  assign irq = irq_ff;

endmodule

//--- ipais_host_model.sv
// Host bus model: drives address, enable, strobes and the card's configuration pins.
// Assumes the bench calls its tasks from one process, one bus cycle at a time.
`timescale 1ns/1ps
module ipais_host_model (
  input wire logic clk,
  output logic [ipais_pkg::ADDR_W-1:0] isaAddr,
  output logic isaAen,
  output logic isaIorN,
  output logic isaIowN,
  output logic [ipais_pkg::SW_W-1:0] baseSwitch,
  output logic slotWide
);
  import ipais_pkg::*;

  // Idle bus at time zero, card set to a legal base in a wide slot.
  initial begin
    isaAddr = 10'h000;
    isaAen = 1'b0;
    isaIorN = 1'b1;
    isaIowN = 1'b1;
    baseSwitch = 7'h40;
    slotWide = 1'b1;
  end

  // In the host decode test the configurer only picks bases inside the legal window.
  function automatic logic legalBase(input logic [6:0] sw, input logic wide);
    logic [10:0] base;
    base = {1'b0, sw, 3'h0};
    return base >= {1'b0, wide ? AT_MIN : XT_MIN} && base <= 11'h3e0 &&
      !(base <= {1'b0, DISK_HI} && base + 11'h01f >= {1'b0, DISK_LO});
  endfunction

  task automatic configure(input logic [6:0] sw, input logic wide);
    @(posedge clk);
    baseSwitch <= sw;
    slotWide <= wide;
  endtask

  task automatic cycle(input logic [9:0] a, input logic aen, input logic rd);
    @(posedge clk);
    isaAddr <= a;
    isaAen <= aen;
    isaIorN <= !rd;
    isaIowN <= rd;
  endtask

  // Released address lines show the inverse, so a stale value cannot pass.
  task automatic idle();
    @(posedge clk);
    isaAddr <= ~isaAddr;
    isaIorN <= 1'b1;
    isaIowN <= 1'b1;
  endtask
endmodule

//--- ipais_asserts.sv
// Checker for the card select logic, bound to the top module.
// Assumes pins settle for several cycles; decode is judged only after they do.
`timescale 1ns/1ps
module ipais_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [ipais_pkg::ADDR_W-1:0] isaAddr,
  input wire logic isaAen,
  input wire logic isaIorN,
  input wire logic isaIowN,
  input wire logic [ipais_pkg::SW_W-1:0] baseSwitch,
  input wire logic slotWide,
  input wire logic [ipais_pkg::NPORT-1:0] portSel,
  input wire logic [ipais_pkg::REG_SEL_W-1:0] regSel,
  input wire logic dataOe,
  input wire logic [ipais_pkg::IRQ_W-1:0] isaIrqLvl,
  input wire logic [ipais_pkg::IRQ_W-1:0] isaIrqOe
);
  import ipais_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [9:0] addrPrev_ff, nxt_addrPrev;
  logic [6:0] swPrev_ff, nxt_swPrev;
  logic [2:0] ctlPrev_ff, nxt_ctlPrev, stableCnt_ff, nxt_stableCnt;
  logic [3:0] expSel;

  // Count quiet cycles of the decode pins; synchroniser and output register delay the decode by three cycles.
  always_comb begin
    nxt_addrPrev = isaAddr;
    nxt_swPrev = baseSwitch;
    nxt_ctlPrev = {isaAen, isaIorN, isaIowN};
    nxt_stableCnt = stableCnt_ff;
    if ({isaAddr, baseSwitch, nxt_ctlPrev} != {addrPrev_ff, swPrev_ff, ctlPrev_ff})
      nxt_stableCnt = 3'h0;
    else if (stableCnt_ff != 3'h7)
      nxt_stableCnt = stableCnt_ff + 3'h1;
    for (int k = 0; k < 4; k++)
      expSel[k] = !ctlPrev_ff[2] && {1'b0, addrPrev_ff[9:3]} == {1'b0, swPrev_ff} + 8'(k);
  end

  // Register the helper state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrPrev_ff <= 10'h000;
      swPrev_ff <= 7'h00;
      ctlPrev_ff <= 3'h0;
      stableCnt_ff <= 3'h0;
    end else begin
      addrPrev_ff <= nxt_addrPrev;
      swPrev_ff <= nxt_swPrev;
      ctlPrev_ff <= nxt_ctlPrev;
      stableCnt_ff <= nxt_stableCnt;
    end
  end

  sequence narrowHeld;
    (!slotWide) [*5];
  endsequence
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence

  chk_base_match: assert property (stableCnt_ff >= 3'h5 |-> portSel == expSel)
    else $error("Port select does not follow the base match.");
  chk_reg_select: assert property (stableCnt_ff >= 3'h5 |-> regSel == addrPrev_ff[2:0])
    else $error("Register select differs from low address bits.");
  chk_data_drive: assert property (stableCnt_ff >= 3'h5 |->
    dataOe == (|expSel && !ctlPrev_ff[1] && ctlPrev_ff[0]))
    else $error("Data drive does not match a decoded read.");
  chk_bus_release: assert property (portSel == 4'h0 |-> !dataOe)
    else $error("Data driven outside the decoded range.");
  chk_irq_lines: assert property (isaIrqOe[13] == 1'b0 && isaIrqOe[9:8] == 2'h0 &&
    isaIrqOe[1:0] == 2'h0 && (isaIrqLvl & ~isaIrqOe) == 16'h0000)
    else $error("Interrupt driven on a line that is not offered.");
  chk_irq_count: assert property ($countones(isaIrqOe) <= NPORT)
    else $error("More lines driven than there are ports.");
  chk_narrow_off: assert property (narrowHeld |-> isaIrqOe[15:10] == 6'h00)
    else $error("High interrupt line driven in a narrow slot.");
  chk_write_answer: assert property (wrTaken |=> bvalid && !awready && !wready)
    else $error("Write response missing after address and data.");
  chk_write_close: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("Write channel not reopened after response.");
  chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("Read data missing after address.");
endmodule

bind isa_port_address_irq_select ipais_asserts chk (.clk, .rst, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .isaAddr, .isaAen, .isaIorN,
  .isaIowN, .baseSwitch, .slotWide, .portSel, .regSel, .dataOe, .isaIrqLvl, .isaIrqOe);

//--- isa_port_address_irq_select_tb.sv
// Self-checking bench: register bus, host decode, interrupt routing and events.
// Assumes the host model, the checker bind and the design package are compiled first.
`timescale 1ns/1ps
module isa_port_address_irq_select_tb;
  import ipais_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, isaAen, isaIorN, isaIowN, slotWide, dataOe, irq, wide, rd, aen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [3:0] wstrb, portReq, portSel, req, exp4;
  logic [1:0] bresp, rresp, r;
  logic [9:0] isaAddr, a;
  logic [6:0] baseSwitch, sw;
  logic [2:0] regSel;
  logic [15:0] isaIrqLvl, isaIrqOe, route;
  int errCount, totalChecks, seed, i, off;
  int corner[6] = '{0, 7, 24, 31, 32, -1};
  logic [7:0] regA[4] = '{OFF_ROUTE, OFF_STATUS, OFF_MASK, 8'h10};

  isa_port_address_irq_select dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .isaAddr, .isaAen, .isaIorN, .isaIowN, .baseSwitch, .slotWide,
    .portReq, .portSel, .regSel, .dataOe, .isaIrqLvl, .isaIrqOe, .irq);
  ipais_host_model host (.clk, .isaAddr, .isaAen, .isaIorN, .isaIowN, .baseSwitch, .slotWide);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // **********************************
  // Expectations and bus tasks
  // **********************************
  function automatic logic [3:0] expSel(input logic [6:0] s, input logic [9:0] x,
                                        input logic e);
    for (int k = 0; k < 4; k++)
      expSel[k] = !e && {1'b0, x[9:3]} == {1'b0, s} + 8'(k);
  endfunction

  // Packs {levels, enables}; shared lines are the OR of their ports.
  function automatic logic [31:0] expIrq(input logic [15:0] rt, input logic [3:0] q,
                                         input logic w);
    logic [3:0] c;
    expIrq = 32'h0;
    for (int k = 0; k < 4; k++) begin
      c = rt[4*k +: 4];
      if ((c >= IRQ_LOW_MIN && c <= IRQ_LOW_MAX) ||
          (w && c >= IRQ_HIGH_MIN && c != IRQ_RESERVED)) begin
        expIrq[c] = 1'b1;
        expIrq[16 + c] = expIrq[16 + c] | q[k];
      end
    end
  endfunction

  task automatic endOfTest();
    if (errCount == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic axiWrite(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= ad;
    awvalid <= 1'b1;
    wdata <= dt;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 40) begin
        errCount++;
        endOfTest();
      end
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 40) begin
        errCount++;
        endOfTest();
      end
    end while (rvalid !== 1'b1);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // **********************************
  // Main sequence
  // **********************************
  initial begin
    seed = 45;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {wstrb, portReq} = 8'hf0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, an unmapped word and the read-only word.
    for (i = 0; i < 4; i++) begin
      axiRead(regA[i], d, r);
      check(d, 32'h0);
      check(32'(r), 32'(i == 3 ? RESP_SLVERR : RESP_OKAY));
    end
    axiWrite(OFF_INFO, 32'h0, r);
    check(32'(r), 32'(RESP_SLVERR));
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      axiWrite(OFF_MASK, v, r);
      axiRead(OFF_MASK, d, r);
      check(d, v & 32'h1f);
      axiWrite(OFF_ROUTE, v, r);
      axiRead(OFF_ROUTE, d, r);
      check(d, v & 32'hffff);
    end
    // Host decode at block edges first, then random offsets around the card.
    for (i = 0; i < 30; i++) begin
      sw = (i == 0) ? 7'h7c : 7'($random(seed));
      wide = 1'($random(seed));
      while (!host.legalBase(sw, wide)) sw = 7'($random(seed));
      host.configure(sw, wide);
      off = (i < 6) ? corner[i] : ($random(seed) & 63) - 16;
      a = {sw, 3'h0} + 10'(off);
      aen = i >= 6 && ($random(seed) & 3) == 0;
      rd = 1'($random(seed));
      host.cycle(a, aen, rd);
      repeat (5) @(posedge clk);
      exp4 = expSel(sw, a, aen);
      check(32'(portSel), 32'(exp4));
      check(32'(regSel), 32'(a[2:0]));
      check(32'(dataOe), 32'(|exp4 && rd));
      host.idle();
    end
    // Every level code in both slot widths, then shared and random routes.
    for (i = 0; i < 40; i++) begin
      wide = (i < 32) ? i[4] : 1'($random(seed));
      route = (i < 32) ? {12'h0, i[3:0]} : (i < 35 ? 16'h5555 : 16'($random(seed)));
      req = (i < 32) ? 4'h1 : 4'($random(seed));
      host.configure(7'h40, wide);
      portReq <= req;
      axiWrite(OFF_ROUTE, 32'(route), r);
      repeat (6) @(posedge clk);
      check({isaIrqLvl, isaIrqOe}, expIrq(route, req, wide));
    end
    // Sticky request event, masking, clearing, and the illegal-base event.
    portReq <= 4'h0;
    repeat (6) @(posedge clk);
    axiWrite(OFF_MASK, 32'h02, r);
    axiWrite(OFF_STATUS, 32'h1f, r);
    axiRead(OFF_STATUS, d, r);
    check(d, 32'h0);
    check(32'(irq), 32'h0);
    portReq <= 4'h2;
    repeat (6) @(posedge clk);
    check(32'(irq), 32'h1);
    axiRead(OFF_STATUS, d, r);
    check(d, 32'h2);
    axiRead(OFF_INFO, d, r);
    check(d, 32'h40 | 32'(wide) << INFO_WIDE | 32'h2 << INFO_REQ | 32'h1 << INFO_LEGAL);
    axiWrite(OFF_STATUS, 32'h02, r);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    axiWrite(OFF_MASK, 32'h10, r);
    host.configure(7'h00, 1'b1);
    repeat (8) @(posedge clk);
    check(32'(irq), 32'h1);
    axiRead(OFF_STATUS, d, r);
    check(d, 32'h10);
    endOfTest();
  end
endmodule
